// File: rtl/glc_guard_lock.sv
// Contract
// - lock = both p inputs open; unlock = both p high, n line grounded.
// - a failed lock attempt is retried once, then block-drive fault.
// - after block fault, bolt drive stays off until control inputs change.
// - bolt locked at power-up: outputs off until unlock then lock.
// - enabled safety outputs get periodic off test pulses up to 0.4 ms.
// - unlock command switches both safety outputs off at once.
// - lock while actuator in range relocks and re-enables outputs.
// - minor fault: warning, diag output drops, outputs off after 30 min.
// - cleared fault message acknowledged by door open-close or power cycle.
// - unknown actuator after power-up starts teach, status LED 1 Hz.
// - after 10 s teach dwell, status LED flashes 5 Hz for power-off.
// - no power-off within 5 minutes aborts teach, fault code 5.
// - taught code committed only when same actuator seen after power-up.
// - single-teach variant pairs once, never teaches again.
// - repeat-teach variant teaches any number; new code replaces old.
// - after new code in repeat-teach variant, outputs inhibited ten minutes, power LED flashes.
// - power loss during inhibit restarts full inhibit at power-up.
// - three LEDs: supply, operating condition, fault flash codes.
// - internal error disables both safety outputs immediately.
// - invalid control inputs flagged but never shut outputs down.
// - warning clears itself once its cause is gone.
// - block-drive fault shown as code 8, outputs off at once.
`timescale 1ns/10ps
module glc_guard_lock #(
  parameter logic [39:0] WARN_CYC = glc_pkg::WARN_CYC,
  parameter logic [39:0] INHIBIT_CYC = glc_pkg::INHIBIT_CYC,
  parameter logic [39:0] TEACH_OFF_CYC = glc_pkg::TEACH_OFF_CYC,
  parameter logic [39:0] TEACH_DWELL_CYC = glc_pkg::TEACH_DWELL_CYC,
  parameter logic [39:0] TPULSE_CYC = glc_pkg::TPULSE_CYC,
  parameter logic [39:0] TPERIOD_CYC = glc_pkg::TPERIOD_CYC,
  parameter logic [39:0] LOCK_TMO_CYC = glc_pkg::LOCK_TMO_CYC,
  parameter logic [39:0] BLINK_CYC = glc_pkg::BLINK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lock_cmd_p_first,
  input wire logic lock_cmd_p_second,
  input wire logic lock_cmd_n_line,
  input wire logic bolt_locked,
  input wire logic actuator_present,
  input wire logic actuator_code_match,
  input wire logic internal_error,
  input wire logic warn_fault,
  input wire logic [2:0] warn_code,
  input wire logic nv_code_stored,
  input wire logic nv_pending,
  input wire logic nv_inhibit,
  output logic bolt_extend,
  output logic safety_chan_a,
  output logic safety_chan_b,
  output logic diag_signal_first,
  output logic diag_signal_second,
  output logic led_power,
  output logic led_status,
  output logic led_fault,
  output logic nv_write_pending,
  output logic nv_commit,
  output logic inhibit_active
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0] pin_raw;
  logic [13:0] pin_m_r;
  logic [13:0] pin_s_r;
  assign pin_raw = {nv_inhibit, nv_pending, nv_code_stored, warn_code, warn_fault,
                    internal_error, actuator_code_match, actuator_present, bolt_locked,
                    lock_cmd_n_line, lock_cmd_p_second, lock_cmd_p_first};
  // two stages; only the second one is read by logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_m_r <= 14'h0000;
      pin_s_r <= 14'h0000;
    end
    else
    begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
    end
  end
  logic p1_s, p2_s, n_s, bolt_s, act_s, match_s, ierr_s, warn_s;
  logic [2:0] wcode_s;
  logic stored_s, pend_s, nvinh_s;
  assign {nvinh_s, pend_s, stored_s, wcode_s, warn_s, ierr_s, match_s, act_s, bolt_s,
          n_s, p2_s, p1_s} = pin_s_r;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [4:0] ctrl_r;
  logic dph_wr_r;
  logic [11:0] dph_addr_r;
  logic aph_take;
  logic [31:0] stat_word;
  assign aph_take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1; // zero wait states, every transfer OKAY
  assign hresp = 1'b0;
  // address phase capture; hsize ignored, only word accesses are used
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 12'h000;
    end
    else
    begin
      dph_wr_r <= aph_take && hwrite;
      dph_addr_r <= haddr[11:0];
    end
  end
  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (aph_take && !hwrite)
    begin
      if (haddr[11:0] == glc_pkg::CTRL_OFS)
        hrdata <= {27'h0, ctrl_r};
      else if (haddr[11:0] == glc_pkg::STAT_OFS)
        hrdata <= stat_word;
      else
        hrdata <= 32'h0000_0000; // unmapped reads as zero
    end
  end
  // variant configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= glc_pkg::CTRL_RST;
    else if (dph_wr_r && dph_addr_r == glc_pkg::CTRL_OFS)
      ctrl_r <= hwdata[4:0];
  end
  logic pn_var, dual_var, indiv_var, single_var, repeat_var;
  assign pn_var = ctrl_r[glc_pkg::CTRL_PN];
  assign dual_var = ctrl_r[glc_pkg::CTRL_DUAL];
  assign indiv_var = ctrl_r[glc_pkg::CTRL_INDIV];
  assign single_var = ctrl_r[glc_pkg::CTRL_SINGLE];
  assign repeat_var = ctrl_r[glc_pkg::CTRL_REPEAT];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic cmd_lock, cmd_unlock, cmd_bad;
  // n line high means open; in P/P it is grounded for both commands
  assign cmd_lock = !p1_s && !p2_s && (pn_var ? n_s : !n_s);
  assign cmd_unlock = p1_s && p2_s && !n_s;
  assign cmd_bad = !cmd_lock && !cmd_unlock;

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  glc_pkg::glc_state_t state_r, state_nxt;
  logic [39:0] tmr_r;
  logic [1:0] init_cnt_r;
  logic [2:0] blk_cmd_r;
  logic relock_r, inh_r, teach_ok, commit_now, commit_done_r;
  // a single-teach unit that already holds a code never teaches again
  assign teach_ok = indiv_var && !pend_s && act_s && !match_s
                    && (repeat_var || (single_var && !stored_s));
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      glc_pkg::ST_INIT:
        if (init_cnt_r == glc_pkg::INIT_WAIT)
          state_nxt = bolt_s ? glc_pkg::ST_LOCKED : glc_pkg::ST_UNLOCKED;
      glc_pkg::ST_UNLOCKED:
        if (teach_ok)
          state_nxt = glc_pkg::ST_TEACH_DWELL;
        else if (cmd_lock && act_s)
          state_nxt = glc_pkg::ST_LOCKING;
      glc_pkg::ST_LOCKING, glc_pkg::ST_RETRY:
        if (cmd_unlock)
          state_nxt = glc_pkg::ST_UNLOCKED;
        else if (bolt_s)
          state_nxt = glc_pkg::ST_LOCKED;
        else if (tmr_r == LOCK_TMO_CYC - 40'd1)
          state_nxt = (state_r == glc_pkg::ST_LOCKING) ? glc_pkg::ST_RETRY
                      : glc_pkg::ST_BLOCK;
      glc_pkg::ST_LOCKED:
        if (cmd_unlock)
          state_nxt = glc_pkg::ST_UNLOCKED;
      glc_pkg::ST_BLOCK:
        if ({cmd_lock, cmd_unlock, cmd_bad} != blk_cmd_r)
          state_nxt = glc_pkg::ST_UNLOCKED;
      glc_pkg::ST_TEACH_DWELL:
        if (tmr_r == TEACH_DWELL_CYC - 40'd1)
          state_nxt = glc_pkg::ST_TEACH_OFF;
      glc_pkg::ST_TEACH_OFF:
        if (tmr_r == TEACH_OFF_CYC - 40'd1)
          state_nxt = glc_pkg::ST_TEACH_ABORT;
      glc_pkg::ST_TEACH_ABORT:
        state_nxt = glc_pkg::ST_TEACH_ABORT; // left only by a power cycle
      default:
        state_nxt = glc_pkg::ST_INIT;
    endcase
  end
  // state register and its entry-restarted timer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= glc_pkg::ST_INIT;
      tmr_r <= 40'h0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= (state_nxt != state_r) ? 40'h0 : tmr_r + 40'd1;
    end
  end
  // wait for the synchronisers to fill before sampling the bolt at start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      init_cnt_r <= 2'h0;
    else if (state_r == glc_pkg::ST_INIT)
      init_cnt_r <= init_cnt_r + 2'h1;
  end
  // command seen when the block fault was entered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      blk_cmd_r <= 3'h0;
    else if (state_nxt == glc_pkg::ST_BLOCK && state_r != glc_pkg::ST_BLOCK)
      blk_cmd_r <= {cmd_lock, cmd_unlock, cmd_bad};
  end
  // bolt found locked at start needs an unlock before outputs may come on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      relock_r <= 1'b0;
    else if (state_r == glc_pkg::ST_INIT && state_nxt == glc_pkg::ST_LOCKED)
      relock_r <= 1'b1;
    else if (cmd_unlock)
      relock_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // code commit and tamper inhibit
  // ----------------------------------------------------------------
  assign commit_now = pend_s && act_s && match_s && !commit_done_r;
  logic [39:0] inh_tmr_r;
  logic inh_wait_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      commit_done_r <= 1'b0;
    else if (commit_now)
      commit_done_r <= 1'b1;
  end
  // inhibit restarts from zero on a repeat-teach commit or when storage says it was cut short
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      inh_r <= 1'b0;
      inh_tmr_r <= 40'h0;
      inh_wait_r <= 1'b0;
    end
    else if ((commit_now && repeat_var) || (state_r == glc_pkg::ST_INIT && nvinh_s))
    begin
      inh_r <= 1'b1;
      inh_tmr_r <= 40'h0;
      inh_wait_r <= 1'b1;
    end
    else
    begin
      if (inh_r && inh_tmr_r == INHIBIT_CYC - 40'd1)
        inh_r <= 1'b0;
      inh_tmr_r <= inh_r ? inh_tmr_r + 40'd1 : 40'h0;
      if (!inh_r && act_s)
        inh_wait_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output enable, warning and test pulses
  // ----------------------------------------------------------------
  logic out_en, warn_r, trip_r, door_open_r, tp_a, tp_b;
  logic [39:0] warn_tmr_r, tp_cnt_r;
  assign out_en = state_r == glc_pkg::ST_LOCKED && bolt_s && !cmd_unlock && !relock_r
                  && !inh_r && !ierr_s && !trip_r && act_s;
  // warning is taken only while outputs are enabled and drops with its cause; its timer restarts on each new warning
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      warn_r <= 1'b0;
      warn_tmr_r <= 40'h0;
    end
    else
    begin
      warn_r <= warn_s && (warn_r || out_en);
      warn_tmr_r <= warn_r ? warn_tmr_r + 40'd1 : 40'h0;
    end
  end
  // trip latch: set wins over the door acknowledge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trip_r <= 1'b0;
      door_open_r <= 1'b0;
    end
    else if (warn_r && warn_tmr_r == WARN_CYC - 40'd1)
      trip_r <= 1'b1;
    else if (trip_r && !warn_s)
    begin
      if (!act_s)
        door_open_r <= 1'b1;
      else if (door_open_r)
      begin
        trip_r <= 1'b0;
        door_open_r <= 1'b0;
      end
    end
  end
  // channel a tested first, channel b later in the period, never together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tp_cnt_r <= 40'h0;
    else
      tp_cnt_r <= (tp_cnt_r == TPERIOD_CYC - 40'd1) ? 40'h0 : tp_cnt_r + 40'd1;
  end
  assign tp_a = tp_cnt_r < TPULSE_CYC;
  assign tp_b = tp_cnt_r >= 40'd2 * TPULSE_CYC && tp_cnt_r < 40'd3 * TPULSE_CYC;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      safety_chan_a <= 1'b0;
      safety_chan_b <= 1'b0;
      bolt_extend <= 1'b0;
    end
    else
    begin
      safety_chan_a <= out_en && !tp_a;
      safety_chan_b <= out_en && !tp_b;
      bolt_extend <= state_nxt == glc_pkg::ST_LOCKING || state_nxt == glc_pkg::ST_RETRY
                     || state_nxt == glc_pkg::ST_LOCKED;
    end
  end

  // ----------------------------------------------------------------
  // fault code, blink base and indicators
  // ----------------------------------------------------------------
  logic [3:0] fcode;
  logic [39:0] blk_cnt_r;
  logic [4:0] fl_cnt_r;
  logic [2:0] slow_cnt_r;
  logic tick, fast_r, slow_r, flash_on;
  always_comb
  begin
    if (ierr_s)
      fcode = glc_pkg::FC_INTERNAL;
    else if (state_r == glc_pkg::ST_TEACH_ABORT)
      fcode = glc_pkg::FC_ACTUATOR;
    else if (state_r == glc_pkg::ST_BLOCK)
      fcode = glc_pkg::FC_BLOCK;
    else if (warn_r || trip_r)
      fcode = {1'b0, wcode_s};
    else if (cmd_bad)
      fcode = glc_pkg::FC_INPUTS;
    else
      fcode = glc_pkg::FC_NONE;
  end
  assign tick = blk_cnt_r == BLINK_CYC - 40'd1;
  // one tick base serves the 5 Hz, 1 Hz and flash code patterns
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blk_cnt_r <= 40'h0;
      fast_r <= 1'b0;
      slow_r <= 1'b0;
      slow_cnt_r <= 3'h0;
      fl_cnt_r <= 5'h00;
    end
    else
    begin
      blk_cnt_r <= tick ? 40'h0 : blk_cnt_r + 40'd1;
      if (tick)
      begin
        fast_r <= !fast_r;
        slow_cnt_r <= (slow_cnt_r == glc_pkg::SLOW_TICKS - 3'h1) ? 3'h0 : slow_cnt_r + 3'h1;
        if (slow_cnt_r == glc_pkg::SLOW_TICKS - 3'h1)
          slow_r <= !slow_r;
        // code pulses then a four-tick pause
        fl_cnt_r <= (fl_cnt_r >= {fcode, 1'b0} + 5'd3) ? 5'h00 : fl_cnt_r + 5'h01;
      end
    end
  end
  assign flash_on = fl_cnt_r < {fcode, 1'b0} && !fl_cnt_r[0];
  logic teach_st;
  assign teach_st = state_r == glc_pkg::ST_TEACH_DWELL || state_r == glc_pkg::ST_TEACH_OFF;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_power <= 1'b0;
      led_status <= 1'b0;
      led_fault <= 1'b0;
    end
    else
    begin
      led_power <= teach_st ? 1'b0 : (inh_r || inh_wait_r) ? slow_r : 1'b1;
      if (state_r == glc_pkg::ST_TEACH_DWELL)
        led_status <= slow_r;
      else if (state_r == glc_pkg::ST_TEACH_OFF)
        led_status <= fast_r;
      else if (state_r == glc_pkg::ST_LOCKED)
        led_status <= out_en || warn_r;
      else
        led_status <= act_s && state_r != glc_pkg::ST_BLOCK && slow_r;
      led_fault <= teach_st || fcode == glc_pkg::FC_INTERNAL || flash_on;
    end
  end
  // diagnostic outputs, storage strobes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      diag_signal_first <= 1'b0;
      diag_signal_second <= 1'b0;
      nv_write_pending <= 1'b0;
      nv_commit <= 1'b0;
    end
    else
    begin
      diag_signal_first <= dual_var ? bolt_s
                           : act_s && !warn_r && !trip_r && !ierr_s
                             && (state_r == glc_pkg::ST_LOCKED || state_r == glc_pkg::ST_UNLOCKED);
      diag_signal_second <= dual_var && act_s && !warn_r && !trip_r && !ierr_s;
      nv_write_pending <= state_nxt == glc_pkg::ST_TEACH_OFF
                          && state_r == glc_pkg::ST_TEACH_DWELL;
      nv_commit <= commit_now;
    end
  end
  assign inhibit_active = inh_r;
  assign stat_word = {8'h00, warn_r, trip_r, relock_r, inh_r, cmd_bad, out_en, bolt_s, act_s,
                      fcode, 3'h0, state_r};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  unlock_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_unlock |=> !safety_chan_a && !safety_chan_b) else $error("outputs on during unlock");
  retry_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_LOCKING && state_nxt != state_r && !bolt_s && !cmd_unlock
    |=> state_r == glc_pkg::ST_RETRY) else $error("no retry after failed lock");
  block_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_BLOCK && $stable({cmd_lock, cmd_unlock})
    |=> state_r == glc_pkg::ST_BLOCK && !bolt_extend) else $error("block left without change");
  relock_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    relock_r |=> !safety_chan_a) else $error("output on before relock");
  tpulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    out_en && tp_a |=> !safety_chan_a && safety_chan_b) else $error("test pulse missing");
  tpulse_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    out_en && !tp_a && !tp_b |=> safety_chan_a && safety_chan_b)
    else $error("test pulse too long");
  ierr_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ierr_s |=> !safety_chan_a && !safety_chan_b ##0 led_fault) else $error("internal error");
  warn_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    warn_r && out_en && !tp_a |=> safety_chan_a && !diag_signal_second)
    else $error("warning dropped outputs");
  warn_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    warn_r && warn_s && warn_tmr_r == WARN_CYC - 40'd1 |=> trip_r ##1 !safety_chan_a)
    else $error("warning timeout not applied");
  bad_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_LOCKED && cmd_bad |=> state_r == glc_pkg::ST_LOCKED)
    else $error("invalid input left lock");
  teach_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_TEACH_OFF && tmr_r == TEACH_OFF_CYC - 40'd1
    |=> state_r == glc_pkg::ST_TEACH_ABORT && (ierr_s || fcode == glc_pkg::FC_ACTUATOR))
    else $error("teach not aborted");
  block_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_BLOCK && !ierr_s |-> fcode == glc_pkg::FC_BLOCK ##1 !safety_chan_a)
    else $error("block fault code wrong");
  outs_on_c: cover property (@(posedge hclk) disable iff (!hresetn) safety_chan_a && safety_chan_b);
  block_c: cover property (@(posedge hclk) disable iff (!hresetn) state_r == glc_pkg::ST_BLOCK);
  trip_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(trip_r));
  abort_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state_r == glc_pkg::ST_TEACH_ABORT);
endmodule

// File: rtl/glc_pkg.sv
package glc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned WARN_MIN = 30;
  localparam int unsigned INHIBIT_MIN = 10;
  localparam int unsigned TEACH_OFF_MIN = 5;
  localparam int unsigned TEACH_DWELL_S = 10;
  localparam real TPULSE_MS = 0.4;
  localparam int unsigned TPERIOD_MS = 100;
  localparam int unsigned LOCK_TMO_MS = 500;
  localparam int unsigned BLINK_MS = 100;
  localparam logic [39:0] WARN_CYC = 40'(64'(WARN_MIN) * 64'd60 * 64'(CLK_HZ));
  localparam logic [39:0] INHIBIT_CYC = 40'(64'(INHIBIT_MIN) * 64'd60 * 64'(CLK_HZ));
  localparam logic [39:0] TEACH_OFF_CYC = 40'(64'(TEACH_OFF_MIN) * 64'd60 * 64'(CLK_HZ));
  localparam logic [39:0] TEACH_DWELL_CYC = 40'(64'(TEACH_DWELL_S) * 64'(CLK_HZ));
  localparam logic [39:0] TPULSE_CYC = 40'($rtoi(TPULSE_MS * real'(CLK_HZ) / 1000.0));
  localparam logic [39:0] TPERIOD_CYC = 40'(64'(TPERIOD_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [39:0] LOCK_TMO_CYC = 40'(64'(LOCK_TMO_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [39:0] BLINK_CYC = 40'(64'(BLINK_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [2:0] SLOW_TICKS = 3'h5;
  localparam logic [1:0] INIT_WAIT = 2'h3;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int CTRL_PN = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_INDIV = 2;
  localparam int CTRL_SINGLE = 3;
  localparam int CTRL_REPEAT = 4;
  localparam int STAT_CODE_LSB = 12;
  localparam int STAT_FLAG_LSB = 16;
  // ----------------------------------------------------------------
  // fault codes and states
  // ----------------------------------------------------------------
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_ACTUATOR = 4'h5;
  localparam logic [3:0] FC_INPUTS = 4'h6;
  localparam logic [3:0] FC_BLOCK = 4'h8;
  localparam logic [3:0] FC_INTERNAL = 4'hF;
  typedef enum logic [8:0] {
    ST_INIT = 9'h001,
    ST_UNLOCKED = 9'h002,
    ST_LOCKING = 9'h004,
    ST_RETRY = 9'h008,
    ST_LOCKED = 9'h010,
    ST_BLOCK = 9'h020,
    ST_TEACH_DWELL = 9'h040,
    ST_TEACH_OFF = 9'h080,
    ST_TEACH_ABORT = 9'h100
  } glc_state_t;
endpackage

// File: verif/glc_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// safety controller model
// ----------------------------------------------------------------
module glc_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] cmd,
  input wire logic pn,
  input wire logic chan_a,
  input wire logic chan_b,
  output logic lock_cmd_p_first,
  output logic lock_cmd_p_second,
  output logic lock_cmd_n_line,
  output logic disc_long
);
  // channel disagreement shorter than this many cycles is blanked as a test pulse
  localparam logic [2:0] BLANK_CYC = 3'h5;
  logic [2:0] disc_cnt_r;
  // cmd 0 lock, 1 unlock, 2 invalid mix; n line opens for lock only in p/n wiring
  always_ff @(posedge hclk)
  begin
    lock_cmd_p_first <= (cmd != 2'h0);
    lock_cmd_p_second <= (cmd == 2'h1);
    lock_cmd_n_line <= pn && cmd == 2'h0;
  end
  // a longer discrepancy would trip the controller, so it latches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      disc_cnt_r <= 3'h0;
      disc_long <= 1'b0;
    end
    else
    begin
      disc_cnt_r <= (chan_a != chan_b) ? disc_cnt_r + 3'h1 : 3'h0;
      if (chan_a != chan_b && disc_cnt_r == BLANK_CYC - 3'h1)
        disc_long <= 1'b1;
    end
  end
endmodule

// File: verif/glc_guard_lock_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// guard lock bench
// ----------------------------------------------------------------
module glc_guard_lock_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bolt_locked = 1'b0;
  logic act = 1'b1, ierr = 1'b0, warn = 1'b0, pn = 1'b0, match = 1'b1, stored = 1'b0;
  logic pend = 1'b0, nvinh = 1'b0;
  logic [1:0] htrans = 2'h0, cmd = 2'h0, ph = 2'h0;
  logic [2:0] wcode = 3'h1, hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h2C8D;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int fail_count = 0, tests_run = 0;
  wire logic hreadyout, hresp, p1, p2, nl, bext, sa, sb;
  wire logic disc, d1, d2, lpw, lst, lft, nvw, nvc, inh;
  wire logic [31:0] hrdata;
  always #12.5 hclk = ~hclk;
  glc_ctrl_model i_glc_ctrl_model (.hclk, .hresetn, .cmd, .pn, .chan_a(sa), .chan_b(sb),
    .lock_cmd_p_first(p1), .lock_cmd_p_second(p2), .lock_cmd_n_line(nl), .disc_long(disc));
  // short counts keep timeouts and the warning delay inside a quick run
  glc_guard_lock #(.LOCK_TMO_CYC(40'h14), .WARN_CYC(40'h32), .TPULSE_CYC(40'h4),
    .TPERIOD_CYC(40'h28)) i_glc_guard_lock (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .lock_cmd_p_first(p1), .lock_cmd_p_second(p2), .lock_cmd_n_line(nl),
    .bolt_locked, .actuator_present(act), .actuator_code_match(match),
    .internal_error(ierr), .warn_fault(warn), .warn_code(wcode), .nv_code_stored(stored),
    .nv_pending(pend), .nv_inhibit(nvinh), .bolt_extend(bext), .safety_chan_a(sa),
    .safety_chan_b(sb), .diag_signal_first(d1), .diag_signal_second(d2), .led_power(lpw),
    .led_status(lst), .led_fault(lft), .nv_write_pending(nvw), .nv_commit(nvc),
    .inhibit_active(inh));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single word transfer; read notes {mask, value} for the monitor
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [63:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back(e);
    ph <= {1'b0, !w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    ph <= 2'h0;
  endtask
  task automatic rd(input logic [31:0] a, m, e);
    bus(1'b0, a, 32'h0, {m, e});
  endtask
  // pin sample, packed as in the monitor; an edge first so ph is set once per step
  task automatic pk(input logic [31:0] m, e);
    exp_q.push_back({m, e});
    @(posedge hclk);
    ph <= 2'h2;
    @(posedge hclk);
    ph <= 2'h0;
  endtask
  // takes the oldest note whenever a read or pin sample lands
  always @(posedge hclk)
    if (ph != 2'h0)
    begin
      note = exp_q.pop_front();
      chk(ph == 2'h1 ? "hrdata" : "pins", (ph == 2'h1 ? hrdata
        : {19'h0, lst, hresp, nvw, nvc, inh, lft, lpw, d2, d1, disc, bext, sa, sb})
        & note[63:32], note[31:0]);
    end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    wt(3000);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    wt(5);
    hresetn <= 1'b1;
    wt(6);
    rd(32'h0, 32'h1F, 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, 32'h0, rnd & 32'h1E, 64'h0);
    rd(32'h0, 32'hFFFFFFFF, rnd & 32'h1E);
    bus(1'b1, 32'h0, 32'h0, 64'h0);
    rd(32'h8, 32'hFFFFFFFF, 32'h0);
    rd(32'h4, 32'h1FF, 32'h4);
    pk(32'h4, 32'h4);
    bolt_locked <= 1'b1;
    wt(6);
    rd(32'h4, 32'h401FF, 32'h40010);
    cmd <= 2'h1;
    wt(4);
    pk(32'h3, 32'h0);
    bus(1'b1, 32'h0, 32'h1, 64'h0);
    pn <= 1'b1;
    cmd <= 2'h0;
    wt(6);
    rd(32'h4, 32'h40000, 32'h40000);
    cmd <= 2'h2;
    wt(6);
    rd(32'h4, 32'h4F1FF, 32'h46010);
    cmd <= 2'h0;
    rnd = lfsr(rnd);
    wcode <= 3'(rnd[1:0]) + 3'h1;
    warn <= 1'b1;
    wt(6);
    rd(32'h4, 32'hC40000, 32'h840000);
    pk(32'h1870, 32'h1040);
    wt(60);
    rd(32'h4, 32'h440000, 32'h400000);
    warn <= 1'b0;
    act <= 1'b0;
    wt(6);
    act <= 1'b1;
    wt(6);
    rd(32'h4, 32'hC00000, 32'h0);
    cmd <= 2'h1;
    bolt_locked <= 1'b0;
    wt(6);
    cmd <= 2'h0;
    wt(70);
    rd(32'h4, 32'hF1FF, 32'h8020);
    pk(32'h4, 32'h0);
    cmd <= 2'h1;
    wt(6);
    rd(32'h4, 32'h1FF, 32'h2);
    cmd <= 2'h0;
    wt(4);
    bolt_locked <= 1'b1;
    wt(6);
    ierr <= 1'b1;
    wt(4);
    pk(32'h3, 32'h0);
    rd(32'h4, 32'h40000, 32'h0);
    pk(32'hF88, 32'h80);
    // power cycle with the bolt already in: outputs wait for unlock then lock
    hresetn <= 1'b0;
    ierr <= 1'b0;
    pn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    wt(8);
    rd(32'h4, 32'h2401FF, 32'h200010);
    cmd <= 2'h1;
    wt(6);
    cmd <= 2'h0;
    wt(6);
    rd(32'h4, 32'h2401FF, 32'h40010);
    wt(2);
    report_and_stop();
  end
endmodule
